/* File: pkg/fault_comm_pkg.sv */
package fault_comm_pkg;

  // ==========================================================================
  // Register widths and layout
  // ==========================================================================
  localparam int REG_W = 16;
  // Communication-state-change field inside the reaction control word.
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_MODE_W = 2;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // Status word bits.
  localparam int STAT_OTHER_PENDING = 0;
  localparam int STAT_RESET_LOCKED = 1;
  localparam int STAT_WAIT_RESET = 2;

  // ==========================================================================
  // Reaction modes
  // ==========================================================================
  localparam logic [1:0] MODE_IMMEDIATE = 2'h0;
  localparam logic [1:0] MODE_WAIT_DISABLE = 2'h1;
  localparam logic [1:0] MODE_WAIT_RESET = 2'h2;

  // ==========================================================================
  // Communication states
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_OTHER = 4'h1,
    ST_OP = 4'h2,
    ST_ERR_SAFE_OP = 4'h4,
    ST_RETURN = 4'h8
  } comm_state_t;

endpackage : fault_comm_pkg

/* File: pkg/channel_fault_if.sv */
`timescale 1ns/1ps
interface channel_fault_if;
  logic fault;
  logic enabled;
  logic reset_cmd;
  logic lock_fault;
  logic wait_reset_fault;
  modport ctrl (input fault, enabled, reset_cmd, output lock_fault,
    wait_reset_fault);
  modport chan (output fault, enabled, reset_cmd, input lock_fault,
    wait_reset_fault);
endinterface : channel_fault_if

/* File: design/channel_fault_latch.sv */
`timescale 1ns/1ps
module channel_fault_latch (
  input wire logic clk,
  input wire logic rst,
  input wire logic fault_in,
  input wire logic reset_ok,
  output logic fault_held
);

  typedef struct packed {
    logic held;
  } latch_t;

  latch_t cur;
  latch_t next_cur;

  // A new fault wins over an error reset in the same cycle.
  always_comb begin
    next_cur = cur;
    if (reset_ok) begin
      next_cur.held = 1'b0;
    end
    if (fault_in) begin
      next_cur.held = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign fault_held = cur.held;

endmodule : channel_fault_latch

/* File: design/fatal_error_comm_state_control.sv */
`timescale 1ns/1ps
// What this block does
// - Default: fatal error moves Op to ErrSafe-Op.
// - Either channel's fatal error stops both channels.
// - ErrSafe-Op invalidates actual values and disables group.
// - Mode 0: immediate change, error bit set.
// - Mode 1: change after healthy channel disables.
// - Mode 2: change only on reset command.
// - Bit 0: other channel error awaits our disable.
// - Bit 1: own error awaits other's disable.
// - Error reset refused while bit 1 set.
// - Bit 2: own error awaits reset command.
// - Auto return to Op after reset, flag set.
module fatal_error_comm_state_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic op_request,
  input wire logic safe_op_request,
  input wire logic await_valid_counter_flag,
  input wire logic [1:0] fault,
  input wire logic [1:0] enabled,
  input wire logic [1:0] reset_cmd,
  input wire logic ctrl_wr,
  input wire logic [15:0] ctrl_wdata,
  output logic [15:0] error_reaction_control,
  output logic [15:0] extra_drive_status_0,
  output logic [15:0] extra_drive_status_1,
  output logic in_op,
  output logic state_error,
  output logic values_valid,
  output logic [1:0] channel_stop,
  output logic [1:0] reset_accepted
);

  // ==========================================================================
  // Per-channel fault latches
  // ==========================================================================
  logic [1:0] fault_held;
  logic [1:0] reset_ok;
  channel_fault_if ch_if[2] ();

  for (genvar i = 0; i < 2; i++) begin : g_ch
    assign ch_if[i].fault = fault[i];
    assign ch_if[i].enabled = enabled[i];
    assign ch_if[i].reset_cmd = reset_cmd[i];
    channel_fault_latch u_latch (
      .clk(clk),
      .rst(rst),
      .fault_in(ch_if[i].fault),
      .reset_ok(reset_ok[i]),
      .fault_held(fault_held[i])
    );
  end

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    fault_comm_pkg::comm_state_t state;
    logic err_flag;
    logic [15:0] ctrl;
    logic [1:0] lock;
    logic [1:0] wait_rst;
    logic [1:0] stop;
    logic [1:0] rst_ack;
  } ctl_t;

  ctl_t cur;
  ctl_t next_cur;
  logic [1:0] mode;
  logic any_fault;
  logic go_err;

  function automatic logic other_bit(input logic [1:0] v, input int i);
    return v[1 - i];
  endfunction : other_bit

  assign mode = cur.ctrl[fault_comm_pkg::CTRL_MODE_LSB +:
    fault_comm_pkg::CTRL_MODE_W];
  assign any_fault = |fault_held;

  // Reset is refused while this channel waits on the other one.
  for (genvar i = 0; i < 2; i++) begin : g_rst
    assign reset_ok[i] = reset_cmd[i] & ~cur.lock[i];
  end

  always_comb begin
    next_cur = cur;
    go_err = 1'b0;
    next_cur.rst_ack = reset_ok;
    if (ctrl_wr) begin
      next_cur.ctrl = ctrl_wdata;
    end
    for (int i = 0; i < 2; i++) begin
      next_cur.lock[i] = 1'b0;
      next_cur.wait_rst[i] = 1'b0;
      if (cur.state == fault_comm_pkg::ST_OP && fault_held[i]) begin
        if (mode == fault_comm_pkg::MODE_WAIT_DISABLE &&
            other_bit(enabled, i)) begin
          next_cur.lock[i] = 1'b1;
        end
        if (mode == fault_comm_pkg::MODE_WAIT_RESET) begin
          next_cur.wait_rst[i] = 1'b1;
        end
      end
    end
    case (cur.state)
      fault_comm_pkg::ST_OTHER: begin
        if (op_request && !any_fault) begin
          next_cur.state = fault_comm_pkg::ST_OP;
        end
      end
      fault_comm_pkg::ST_OP: begin
        if (any_fault) begin
          case (mode)
            fault_comm_pkg::MODE_WAIT_DISABLE: begin
              // Healthy channel keeps running until it is disabled.
              go_err = ~(fault_held[0] ? enabled[1] : enabled[0]) |
                (&fault_held);
            end
            fault_comm_pkg::MODE_WAIT_RESET: begin
              go_err = |reset_cmd;
            end
            default: begin
              go_err = 1'b1;
            end
          endcase
        end
        if (go_err) begin
          next_cur.state = fault_comm_pkg::ST_ERR_SAFE_OP;
          next_cur.err_flag = 1'b1;
          next_cur.stop = 2'h3;
          next_cur.lock = 2'h0;
          next_cur.wait_rst = 2'h0;
        end else if (safe_op_request) begin
          next_cur.state = fault_comm_pkg::ST_OTHER;
        end
      end
      fault_comm_pkg::ST_ERR_SAFE_OP: begin
        if (!any_fault) begin
          next_cur.err_flag = 1'b0;
          next_cur.stop = 2'h0;
          next_cur.state = await_valid_counter_flag ?
            fault_comm_pkg::ST_RETURN : fault_comm_pkg::ST_OTHER;
        end
      end
      fault_comm_pkg::ST_RETURN: begin
        next_cur.state = fault_comm_pkg::ST_OP;
      end
      default: begin
        next_cur.state = fault_comm_pkg::ST_OTHER;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '{state: fault_comm_pkg::ST_OTHER,
               ctrl: fault_comm_pkg::CTRL_RESET,
               default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign ch_if[0].lock_fault = cur.lock[0];
  assign ch_if[1].lock_fault = cur.lock[1];
  assign ch_if[0].wait_reset_fault = cur.wait_rst[0];
  assign ch_if[1].wait_reset_fault = cur.wait_rst[1];

  // Reserved bits read as zero; bit 0 mirrors the other channel's lock.
  assign extra_drive_status_0 = {13'h0000, cur.wait_rst[0], cur.lock[0],
    cur.lock[1]};
  assign extra_drive_status_1 = {13'h0000, cur.wait_rst[1], cur.lock[1],
    cur.lock[0]};
  assign error_reaction_control = cur.ctrl;
  assign in_op = cur.state == fault_comm_pkg::ST_OP;
  assign state_error = cur.err_flag;
  assign values_valid = in_op;
  assign channel_stop = cur.stop;
  assign reset_accepted = cur.rst_ack;

endmodule : fatal_error_comm_state_control

/* File: tb/fault_comm_sva.sv */
`timescale 1ns/1ps
module fault_comm_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] fault,
  input wire logic [1:0] reset_cmd,
  input wire logic safe_op_request,
  input wire logic [15:0] error_reaction_control,
  input wire logic [15:0] extra_drive_status_0,
  input wire logic [15:0] extra_drive_status_1,
  input wire logic in_op,
  input wire logic state_error,
  input wire logic values_valid,
  input wire logic [1:0] channel_stop,
  input wire logic [1:0] reset_accepted
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic [1:0] mode = error_reaction_control[5:4];
  a_immediate_leave: assert property (in_op && |fault && !safe_op_request
    && mode != 2'h1 && mode != 2'h2 |-> ##2 (state_error && !in_op))
    else $error("fault did not leave op in two cycles");
  a_both_stopped: assert property (state_error |-> channel_stop == 2'h3)
    else $error("a channel still runs in error state");
  a_error_not_op: assert property (state_error |-> !in_op)
    else $error("error flagged while in op");
  a_values_track: assert property (values_valid == in_op)
    else $error("actual values valid outside op");
  a_reserved_zero: assert property (extra_drive_status_0[15:3] == 13'h0
    && extra_drive_status_1[15:3] == 13'h0) else $error("reserved bit set");
  a_reset_refused: assert property (extra_drive_status_0[1] && reset_cmd[0]
    |=> !reset_accepted[0]) else $error("locked reset accepted");
  a_lock_paired: assert property (extra_drive_status_0[1]
    |-> extra_drive_status_1[0]) else $error("lock without partner flag");
  a_lock_mode: assert property (extra_drive_status_0[1] |-> mode == 2'h1)
    else $error("lock flag in wrong mode");
  a_wait_mode: assert property (extra_drive_status_1[2]
    |-> mode == 2'h2 && in_op) else $error("wait flag in wrong mode");
  a_clear_error: assert property (state_error
    |-> extra_drive_status_0[2:0] == 3'h0) else $error("flag kept in error");
endmodule : fault_comm_sva

/* File: tb/master_model.sv */
`timescale 1ns/1ps
module master_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic leave,
  output logic op_request,
  output logic safe_op_request
);
  // Requests are levels that change only after the falling edge.
  always @(negedge clk) begin
    op_request <= go & ~rst;
    safe_op_request <= leave & ~rst;
  end
endmodule : master_model

/* File: tb/fatal_error_comm_state_control_test.sv */
`timescale 1ns/1ps
module fatal_error_comm_state_control_test;
  logic clk, rst, go, leave, flag, ctrl_wr, op_request, safe_op_request;
  logic in_op, state_error, values_valid;
  logic [1:0] fault, enabled, reset_cmd, channel_stop, reset_accepted;
  logic [15:0] ctrl_wdata, ctrl, st0, st1, outs;
  logic [31:0] lfsr = 32'h0000759F;
  int errors = 0;
  int checks_done = 0;
  int ch, m;
  assign outs = {13'h0000, in_op, state_error, values_valid};
  master_model mm_u (.clk(clk), .rst(rst), .go(go), .leave(leave),
    .op_request(op_request), .safe_op_request(safe_op_request));
  fatal_error_comm_state_control dut_u (.clk(clk), .rst(rst),
    .op_request(op_request), .safe_op_request(safe_op_request),
    .await_valid_counter_flag(flag), .fault(fault), .enabled(enabled),
    .reset_cmd(reset_cmd), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .error_reaction_control(ctrl), .extra_drive_status_0(st0),
    .extra_drive_status_1(st1), .in_op(in_op), .state_error(state_error),
    .values_valid(values_valid), .channel_stop(channel_stop),
    .reset_accepted(reset_accepted));
  function automatic logic [15:0] own_stat(int md);
    return md == 1 ? 16'h0002 : (md == 2 ? 16'h0004 : 16'h0000);
  endfunction : own_stat
  function automatic logic [15:0] other_stat(int md);
    return md == 1 ? 16'h0001 : 16'h0000;
  endfunction : other_stat
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic wait_op(logic want);
    for (int k = 0; k < 40 && in_op !== want; k++) tick(1);
    if (in_op !== want) begin
      errors++;
      $display("[ERR] %0t wait for op state ran out", $time);
      stop_test();
    end
  endtask : wait_op
  initial begin
    clk = 1'b1;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst, flag, enabled} = 4'hF;
    {go, leave, ctrl_wr, fault, reset_cmd, ctrl_wdata} = '0;
    tick(12);
    rst = 1'b0;
    chk(ctrl | st0 | st1, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      ch = i % 2;
      m = i % 3;
      ctrl_wdata = {lfsr[15:6], m[1:0], lfsr[3:0]};
      ctrl_wr = 1'b1;
      go = 1'b1;
      tick(1);
      ctrl_wr = 1'b0;
      chk(ctrl, ctrl_wdata);
      wait_op(1'b1);
      tick(int'(lfsr[18:16]));
      fault[ch] = 1'b1;
      tick(1);
      fault = 2'h0;
      tick(2);
      // Status words are read on the parameter path.
      chk(ch ? st1 : st0, own_stat(m));
      chk(ch ? st0 : st1, other_stat(m));
      chk(outs, m == 0 ? 16'h0002 : 16'h0005);
      if (m == 0) chk({14'h0000, channel_stop}, 16'h0003);
      if (m != 0) begin
        reset_cmd[ch] = 1'b1;
        tick(1);
        reset_cmd = 2'h0;
        if (m == 1) chk({15'h0000, reset_accepted[ch]}, 16'h0000);
        if (m == 2) chk({15'h0000, reset_accepted[ch]}, 16'h0001);
        // The reset command itself moves a mode 2 drive out of Op.
        if (m == 2) chk(outs, 16'h0002);
        enabled[1 - ch] = 1'b0;
        tick(3);
        enabled = 2'h3;
        if (m == 1) chk(outs, 16'h0002);
      end
      chk(st0 | st1, 16'h0000);
      reset_cmd = 2'h3;
      tick(1);
      reset_cmd = 2'h0;
      wait_op(1'b1);
      chk(outs, 16'h0005);
    end
    go = 1'b0;
    leave = 1'b1;
    wait_op(1'b0);
    chk(outs, 16'h0000);
    stop_test();
  end
endmodule : fatal_error_comm_state_control_test
bind fatal_error_comm_state_control fault_comm_sva sva_u (.clk(clk),
  .rst(rst), .fault(fault), .reset_cmd(reset_cmd),
  .safe_op_request(safe_op_request),
  .error_reaction_control(error_reaction_control),
  .extra_drive_status_0(extra_drive_status_0),
  .extra_drive_status_1(extra_drive_status_1), .in_op(in_op),
  .state_error(state_error), .values_valid(values_valid),
  .channel_stop(channel_stop), .reset_accepted(reset_accepted));
